// ---- logic/exc_pkg.sv ----
// exception unit package: machine state bit layout, register map, types
// assumes big-endian bit numbering: architectural bit n sits at [31-n]
package exc_pkg;
	// apb register byte offsets
	localparam logic [7:0] OFF_MSTATE = 8'h00; // machine state
	localparam logic [7:0] OFF_ADDRSAVE = 8'h04; // address save/restore
	localparam logic [7:0] OFF_STATSAVE = 8'h08; // status save/restore
	localparam logic [7:0] OFF_EVENT = 8'h0C; // last taken cause, checkstop
	// machine state bit positions (vector index)
	localparam int POS_POW = 31 - 13;
	localparam int POS_ILE = 31 - 15;
	localparam int POS_EE = 31 - 16;
	localparam int POS_PR = 31 - 17;
	localparam int POS_FP = 31 - 18;
	localparam int POS_ME = 31 - 19;
	localparam int POS_FE0 = 31 - 20;
	localparam int POS_SE = 31 - 21;
	localparam int POS_BE = 31 - 22;
	localparam int POS_FE1 = 31 - 23;
	localparam int POS_LE = 31 - 31;
	localparam int POS_DSRC = 31 - 5;
	// copied into status save: bits 0, 5-9, 16-31 (full-function kept)
	localparam logic [31:0] SAVE_MASK = 32'h87C0FFFF;
	// exception-specific field: bits 2-4 and 10-12
	localparam logic [31:0] INFO_MASK = 32'h38380000;
	// reset values
	localparam logic [31:0] MSTATE_RST = 32'h00000000;
	localparam logic [31:0] SAVE_RST = 32'h00000000;
	localparam logic [3:0] RST_CODE = 4'hF;
	// priority codes of the lower dispatch/execution class
	localparam logic [3:0] PRI_ALIGN = 4'h6;
	localparam logic [3:0] PRI_DBAT = 4'h7;
	localparam logic [3:0] PRI_DSEG = 4'h8;
	localparam logic [3:0] PRI_DPAGE = 4'h9;
	localparam logic [3:0] PRI_DBRK = 4'hA;
	localparam logic [3:0] PRI_TRACE = 4'hB;
	localparam logic [3:0] PRI_NONE = 4'h0;
	// cause bundle from the pipeline for the completing instruction
	typedef struct packed {
		logic [4:0] align; // [4] fp word .. [0] zero-block cache
		logic       dBlockProt; // block translation protection
		logic       dSegment; // direct store segment access
		logic       dPageProt; // page table protection
		logic       dBreak; // data breakpoint match
		logic       isBranch; // completing instruction is a branch
		logic       traceExempt; // return, sync or call: no single step
	} cause_s;
	// event from the ranker
	typedef struct packed {
		logic [3:0] code;
		logic [4:0] alignSub;
		logic       nextAddr;
	} taken_s;
endpackage

// ---- logic/exc_ranker.sv ----
// exception ranker: picks the lowest-numbered pending dispatch cause
// assumes causes describe one instruction at its completion point
`timescale 1ns/1ns
`default_nettype none
module exc_ranker
(
	// causes
	input  wire exc_pkg::cause_s cause,
	input  wire logic            singleStep,
	input  wire logic            branchTrace,
	// result
	output exc_pkg::taken_s      pick
);
	// priority chain, first match wins
	always_comb
	begin
		pick = '0;
		pick.code = exc_pkg::PRI_NONE;
		if (|cause.align)
		begin
			pick.code = exc_pkg::PRI_ALIGN;
			// keep only the highest alignment sub-cause
			if (cause.align[4]) pick.alignSub = 5'h10;
			else if (cause.align[3]) pick.alignSub = 5'h08;
			else if (cause.align[2]) pick.alignSub = 5'h04;
			else if (cause.align[1]) pick.alignSub = 5'h02;
			else pick.alignSub = 5'h01;
		end
		else if (cause.dBlockProt)
			pick.code = exc_pkg::PRI_DBAT;
		else if (cause.dSegment)
			pick.code = exc_pkg::PRI_DSEG;
		else if (cause.dPageProt)
			pick.code = exc_pkg::PRI_DPAGE;
		else if (cause.dBreak)
			pick.code = exc_pkg::PRI_DBRK;
		else if ((singleStep && !cause.traceExempt) || (branchTrace && cause.isBranch))
		begin
			pick.code = exc_pkg::PRI_TRACE;
			pick.nextAddr = 1'b1;
		end
	end
endmodule
`default_nettype wire

// ---- logic/exc_unit.sv ----
// exception unit: ranks late dispatch causes, saves and restores context
// assumes the completion logic presents one instruction per valid cycle
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module exc_unit
(
	// clock, reset, enable
	input  wire logic               clock,
	input  wire logic               rstn,
	input  wire logic               clkEn,
	// apb slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// completion side
	input  wire logic               complValid,
	input  wire logic [31:0]        complAddr,
	input  wire exc_pkg::cause_s    complCause,
	input  wire logic [31:0]        complInfo,
	input  wire logic               returnFromIrq,
	input  wire logic               softReset,
	input  wire logic               extIrq,
	input  wire logic               decrIrq,
	input  wire logic               floatExcReq,
	// asynchronous pins
	input  wire logic               machineCheckPin,
	// control out
	output logic                    excTake,
	output logic      [3:0]         excCode,
	output logic                    asyncTake,
	output logic                    checkStop,
	output logic                    lowPower,
	output logic                    userOnly,
	output logic                    floatDispatchOk,
	output logic                    floatExcPrecise,
	output logic                    bigEndianN
);
	logic [31:0] mstate_q; // machine state
	logic [31:0] addrSave_q; // address save/restore
	logic [31:0] statSave_q; // status save/restore
	logic [3:0]  lastCode_q; // last taken code
	logic        stop_q; // checkstop latch
	logic [1:0]  mcSync_q; // machine check pin synchroniser
	exc_pkg::taken_s pick; // ranked result
	logic        mcLive; // synchronised machine check
	logic        syncTake; // dispatch exception this cycle
	logic        mcTake; // machine check taken this cycle
	logic        anyTake; // any exception entry
	logic        irqTake; // external or decrementer
	logic        apbWr; // apb write strobe
	logic [31:0] saveImage; // value for status save at entry

	// ranker on the completing instruction
	exc_ranker u_rank
	(
		.cause      (complCause),
		.singleStep (mstate_q[exc_pkg::POS_SE]),
		.branchTrace(mstate_q[exc_pkg::POS_BE]),
		.pick       (pick)
	);

	// two-flop synchroniser on the pin
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			mcSync_q <= 2'b00;
		else if (clkEn)
			mcSync_q <= {mcSync_q[0], machineCheckPin};
	end
	assign mcLive = mcSync_q[1];

	// entry decisions; machine check and soft reset ignore handler state
	assign mcTake = mcLive && mstate_q[exc_pkg::POS_ME] && !stop_q;
	assign irqTake = mstate_q[exc_pkg::POS_EE] && (extIrq || decrIrq);
	// only the top code is taken; others are dropped and may recur later
	assign syncTake = complValid && (pick.code != exc_pkg::PRI_NONE) && !stop_q;
	assign anyTake = (mcTake || softReset || syncTake || irqTake) && !stop_q;
	// state bits plus specific info; partial reserved bits are never copied
	assign saveImage = (mstate_q & exc_pkg::SAVE_MASK)
		| (complInfo & exc_pkg::INFO_MASK);
	assign apbWr = psel && penable && pwrite;

	// checkstop: machine check with enable clear
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			stop_q <= 1'b0;
		else if (clkEn && mcLive && !mstate_q[exc_pkg::POS_ME])
			stop_q <= 1'b1;
	end

	// machine state register
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			mstate_q <= exc_pkg::MSTATE_RST;
		else if (clkEn)
		begin
			if (anyTake)
			begin
				// handler context: interrupts off, endian from handler bit
				mstate_q[exc_pkg::POS_EE] <= 1'b0;
				mstate_q[exc_pkg::POS_LE] <= mstate_q[exc_pkg::POS_ILE];
				mstate_q[exc_pkg::POS_PR] <= 1'b0;
				mstate_q[exc_pkg::POS_POW] <= 1'b0;
				mstate_q[exc_pkg::POS_SE] <= 1'b0;
				mstate_q[exc_pkg::POS_BE] <= 1'b0;
			end
			else if (returnFromIrq)
				mstate_q <= (mstate_q & ~exc_pkg::SAVE_MASK)
					| (statSave_q & exc_pkg::SAVE_MASK);
			else if (apbWr && paddr == exc_pkg::OFF_MSTATE)
				mstate_q <= pwdata;
		end
	end

	// save registers, both at vector entry
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			addrSave_q <= exc_pkg::SAVE_RST;
			statSave_q <= exc_pkg::SAVE_RST;
		end
		else if (clkEn)
		begin
			if (anyTake)
			begin
				// faulting instruction not executed, earlier ones retired
				addrSave_q <= (syncTake && pick.nextAddr) ? complAddr + 32'h4
					: complAddr;
				statSave_q <= saveImage;
			end
			else
			begin
				if (apbWr && paddr == exc_pkg::OFF_ADDRSAVE)
					addrSave_q <= pwdata;
				if (apbWr && paddr == exc_pkg::OFF_STATSAVE)
					statSave_q <= pwdata;
			end
		end
	end

	// last taken code for software
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			lastCode_q <= exc_pkg::PRI_NONE;
		else if (clkEn && anyTake)
			lastCode_q <= (mcTake || softReset) ? exc_pkg::RST_CODE
				: (syncTake ? pick.code : exc_pkg::PRI_NONE);
	end

	// apb answer: one wait-free access, unmapped reads zero with error
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (clkEn)
		begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			if (psel && !penable)
			begin
				case (paddr)
					exc_pkg::OFF_MSTATE: prdata <= mstate_q;
					exc_pkg::OFF_ADDRSAVE: prdata <= addrSave_q;
					exc_pkg::OFF_STATSAVE: prdata <= statSave_q;
					exc_pkg::OFF_EVENT: prdata <= {27'h0, stop_q, lastCode_q};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	// registered controls to the pipeline
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			excTake <= 1'b0;
			excCode <= exc_pkg::PRI_NONE;
			asyncTake <= 1'b0;
			checkStop <= 1'b0;
			lowPower <= 1'b0;
			userOnly <= 1'b0;
			floatDispatchOk <= 1'b0;
			floatExcPrecise <= 1'b0;
			bigEndianN <= 1'b0;
		end
		else if (clkEn)
		begin
			excTake <= anyTake;
			excCode <= syncTake ? pick.code : exc_pkg::PRI_NONE;
			asyncTake <= anyTake && !syncTake;
			checkStop <= stop_q;
			lowPower <= mstate_q[exc_pkg::POS_POW];
			userOnly <= mstate_q[exc_pkg::POS_PR];
			floatDispatchOk <= mstate_q[exc_pkg::POS_FP];
			// either mode bit set means precise; both clear ignore
			floatExcPrecise <= floatExcReq && mstate_q[exc_pkg::POS_FP]
				&& (mstate_q[exc_pkg::POS_FE0] || mstate_q[exc_pkg::POS_FE1]);
			bigEndianN <= mstate_q[exc_pkg::POS_LE];
		end
	end

	// entry clears the interrupt enable
	eeClear_a: assert property (@(posedge clock) disable iff (!rstn)
		clkEn && anyTake |=> !mstate_q[exc_pkg::POS_EE])
		else $error("interrupt enable not cleared at entry");
	// endian copy at entry
	leCopy_a: assert property (@(posedge clock) disable iff (!rstn)
		clkEn && anyTake |=> mstate_q[exc_pkg::POS_LE] == $past(mstate_q[exc_pkg::POS_ILE]))
		else $error("endian bit not copied");
	// status save image
	saveImg_a: assert property (@(posedge clock) disable iff (!rstn)
		clkEn && anyTake |=> statSave_q == (($past(mstate_q) & exc_pkg::SAVE_MASK)
		| ($past(complInfo) & exc_pkg::INFO_MASK)))
		else $error("status save image wrong");
	// trace saves next address
	traceNext_a: assert property (@(posedge clock) disable iff (!rstn)
		clkEn && syncTake && pick.code == exc_pkg::PRI_TRACE
		|=> addrSave_q == $past(complAddr) + 32'h4)
		else $error("trace resume address wrong");
	// alignment wins over data faults
	alignWin_a: assert property (@(posedge clock) disable iff (!rstn)
		(|complCause.align) |-> pick.code == exc_pkg::PRI_ALIGN)
		else $error("alignment not ranked first");
	// block protection beats segment
	dataRank_a: assert property (@(posedge clock) disable iff (!rstn)
		!(|complCause.align) && complCause.dBlockProt |-> pick.code == exc_pkg::PRI_DBAT)
		else $error("data fault rank wrong");
	// checkstop when enable clear
	stopEnter_a: assert property (@(posedge clock) disable iff (!rstn)
		clkEn && mcLive && !mstate_q[exc_pkg::POS_ME] |=> stop_q ##1 checkStop || !clkEn)
		else $error("checkstop not entered");
	// return restores saved bits
	rfiRest_a: assert property (@(posedge clock) disable iff (!rstn)
		clkEn && returnFromIrq && !anyTake
		|=> (mstate_q & exc_pkg::SAVE_MASK) == ($past(statSave_q) & exc_pkg::SAVE_MASK))
		else $error("return did not restore state");
endmodule
`default_nettype wire

// ---- testbench/pipe_model.sv ----
// pipeline stand-in: completion-side stimulus for the exception unit
// assumes one core clock; the bench drives it through its tasks
`timescale 1ns/1ns
`default_nettype none
module pipe_model
(
	// clock
	input  wire logic       clock,
	// completion side
	output logic            complValid,
	output logic [31:0]     complAddr,
	output exc_pkg::cause_s complCause,
	output logic [31:0]     complInfo,
	output logic            returnFromIrq,
	output logic            extIrq,
	output logic            floatExcReq,
	output logic            machineCheckPin
);
	// idle levels from time zero
	initial
	begin
		complValid = 1'b0;
		complAddr = 32'h00000000;
		complCause = exc_pkg::cause_s'(11'h000);
		complInfo = 32'h00000000;
		returnFromIrq = 1'b0;
		extIrq = 1'b0;
		floatExcReq = 1'b0;
		machineCheckPin = 1'b0;
	end
	// one instruction per call, nothing after it in flight
	task automatic issue(input logic [10:0] c, input logic [31:0] a);
		begin
			@(posedge clock);
			complValid <= 1'b1;
			complAddr <= a;
			complCause <= exc_pkg::cause_s'(c);
			complInfo <= 32'hFFFFFFFF;
			@(posedge clock);
			complValid <= 1'b0;
			complCause <= exc_pkg::cause_s'(11'h000);
			// released lines show junk, so a held value cannot pass
			complAddr <= ~a;
			complInfo <= 32'h00000000;
		end
	endtask
	// one-cycle pulse on return or machine check pin
	task automatic pulse(input logic mc);
		begin
			@(posedge clock);
			returnFromIrq <= ~mc;
			machineCheckPin <= mc;
			@(posedge clock);
			returnFromIrq <= 1'b0;
			machineCheckPin <= 1'b0;
		end
	endtask
	// level requests
	task automatic levels(input logic ext, input logic flt);
		begin
			@(posedge clock);
			extIrq <= ext;
			floatExcReq <= flt;
		end
	endtask
endmodule
`default_nettype wire

// ---- testbench/test_exception_priority_state_save.sv ----
// bench for the exception unit: apb tasks plus pipeline model
// assumes 25 MHz clock and active-low asynchronous reset
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errTotal++; \
	$display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module test_exception_priority_state_save;
	logic clock, rstn, psel, penable, pwrite, pready, pslverr;
	logic complValid, returnFromIrq, extIrq, floatExcReq, machineCheckPin;
	logic excTake, asyncTake, checkStop, lowPower, userOnly;
	logic floatDispatchOk, floatExcPrecise, bigEndianN, gx, ga, se;
	logic clkEn, softReset, decrIrq; // bench-driven controls
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, complAddr, complInfo, q, base;
	logic [3:0]  excCode, gc;
	exc_pkg::cause_s complCause;
	int          errTotal = 0;
	int          compares = 0;
	logic [10:0] cs [6] = '{11'h030, 11'h018, 11'h00C, 11'h004, 11'h002, 11'h000};
	logic [3:0]  cc [6] = '{4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hB};
	// enable, soft reset and decrementer driven by the bench
	exc_unit uut (.clock(clock), .rstn(rstn), .clkEn(clkEn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.complValid(complValid), .complAddr(complAddr), .complCause(complCause),
		.complInfo(complInfo), .returnFromIrq(returnFromIrq), .softReset(softReset),
		.extIrq(extIrq), .decrIrq(decrIrq), .floatExcReq(floatExcReq),
		.machineCheckPin(machineCheckPin), .excTake(excTake), .excCode(excCode),
		.asyncTake(asyncTake), .checkStop(checkStop), .lowPower(lowPower),
		.userOnly(userOnly), .floatDispatchOk(floatDispatchOk),
		.floatExcPrecise(floatExcPrecise), .bigEndianN(bigEndianN));
	pipe_model pm (.clock(clock), .complValid(complValid), .complAddr(complAddr),
		.complCause(complCause), .complInfo(complInfo),
		.returnFromIrq(returnFromIrq), .extIrq(extIrq), .floatExcReq(floatExcReq),
		.machineCheckPin(machineCheckPin));
	// clock
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// verdict, also reached on an apb transfer timeout
	task automatic reportAndStop();
		$display("errors %0d compares %0d", errTotal, compares);
		if (errTotal == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// one apb transfer, held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		begin
			n = 0;
			@(posedge clock);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clock);
			penable <= 1'b1;
			// pready sampled at the rising edge that completes the access
			do
			begin
				@(posedge clock);
				n++;
			end
			while (pready !== 1'b1 && n < 50);
			if (n >= 50)
			begin
				errTotal++;
				reportAndStop();
			end
			q = prdata;
			se = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	// wait for an entry pulse, bounded
	task automatic waitPulse();
		begin
			gx = 1'b0;
			ga = 1'b0;
			for (int n = 0; n < 20 && !(gx || ga); n++)
			begin
				@(negedge clock);
				gx = (excTake === 1'b1);
				ga = (asyncTake === 1'b1);
				gc = excCode;
			end
		end
	endtask
	// dispatch entry: code, both save registers, new state
	task automatic entry(input logic [10:0] c, input logic [31:0] m, input logic [3:0] k);
		begin
			apb(1'b1, exc_pkg::OFF_MSTATE, m);
			pm.issue(c, 32'h00001000);
			waitPulse();
			`CHK(gx, 1'b1)
			`CHK(gc, k)
			apb(1'b0, exc_pkg::OFF_ADDRSAVE, 32'h00000000);
			`CHK(q, (k == 4'hB) ? 32'h00001004 : 32'h00001000)
			apb(1'b0, exc_pkg::OFF_STATSAVE, 32'h00000000);
			`CHK(q, (m & exc_pkg::SAVE_MASK) | exc_pkg::INFO_MASK)
			apb(1'b0, exc_pkg::OFF_MSTATE, 32'h00000000);
			`CHK({q[exc_pkg::POS_EE], q[exc_pkg::POS_LE]}, 2'b01)
		end
	endtask
	// main sequence
	initial
	begin
		rstn = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		clkEn = 1'b1;
		softReset = 1'b0;
		decrIrq = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		base = 32'h00000001 << exc_pkg::POS_ILE | 32'h00000001 << exc_pkg::POS_EE;
		base = base | 32'h00000001 << exc_pkg::POS_FP | 32'h00000001 << exc_pkg::POS_ME;
		base = base | 32'h00000001 << exc_pkg::POS_FE0 | 32'h00000001;
		repeat (4) @(posedge clock);
		rstn <= 1'b1;
		apb(1'b0, exc_pkg::OFF_STATSAVE, 32'h00000000);
		`CHK(q, exc_pkg::SAVE_RST)
		apb(1'b0, 8'h10, 32'h00000000);
		`CHK(se, 1'b1)
		// state bits to control outputs
		apb(1'b1, exc_pkg::OFF_MSTATE, 32'h00046001);
		pm.levels(1'b0, 1'b1);
		@(negedge clock);
		`CHK({lowPower, userOnly, floatDispatchOk, bigEndianN}, 4'hF)
		`CHK(floatExcPrecise, 1'b0)
		apb(1'b1, exc_pkg::OFF_MSTATE, 32'h00002100);
		// outputs follow the written state one edge later
		repeat (2) @(negedge clock);
		`CHK({userOnly, floatDispatchOk, floatExcPrecise}, 3'h3)
		apb(1'b1, exc_pkg::OFF_MSTATE, 32'h00000100);
		repeat (2) @(negedge clock);
		`CHK({floatDispatchOk, floatExcPrecise}, 2'b00)
		pm.levels(1'b0, 1'b0);
		// ranking
		for (int i = 0; i < 5; i++)
			entry({5'h01 << i, 6'h20}, base, exc_pkg::PRI_ALIGN);
		for (int i = 0; i < 6; i++)
			entry(cs[i], base | ((i == 4) ? 32'h200 : 32'h400), cc[i]);
		apb(1'b1, exc_pkg::OFF_MSTATE, 32'h00000000);
		pm.pulse(1'b0);
		apb(1'b0, exc_pkg::OFF_MSTATE, 32'h00000000);
		`CHK(q & exc_pkg::SAVE_MASK, (base | 32'h400) & exc_pkg::SAVE_MASK)
		// interrupt gated by enable bit
		apb(1'b1, exc_pkg::OFF_MSTATE, base & ~(32'h1 << exc_pkg::POS_EE));
		pm.levels(1'b1, 1'b0);
		waitPulse();
		`CHK(ga, 1'b0)
		apb(1'b1, exc_pkg::OFF_MSTATE, base);
		waitPulse();
		`CHK(ga, 1'b1)
		pm.levels(1'b0, 1'b0);
		// decrementer condition takes the same gated path
		apb(1'b1, exc_pkg::OFF_MSTATE, base);
		@(posedge clock);
		decrIrq <= 1'b1;
		waitPulse();
		`CHK(ga, 1'b1)
		@(posedge clock);
		decrIrq <= 1'b0;
		// machine check enabled, then disabled
		apb(1'b1, exc_pkg::OFF_MSTATE, base);
		pm.pulse(1'b1);
		waitPulse();
		`CHK({ga, checkStop}, 2'b10)
		apb(1'b0, exc_pkg::OFF_EVENT, 32'h00000000);
		`CHK(q[4:0], 5'h0F)
		apb(1'b1, exc_pkg::OFF_MSTATE, 32'h00000000);
		pm.pulse(1'b1);
		repeat (6) @(negedge clock);
		`CHK(checkStop, 1'b1)
		reportAndStop();
	end
endmodule
`default_nettype wire
